// ===== cfps_pkg.sv
package cfps_pkg;

  // Timing and counts, in oscillator clock cycles
  localparam int RAMP_STEPS    = 2048;
  localparam int HICCUP_CYCLES = 2048;
  localparam int FAULT_LIMIT   = 3;
  localparam int RAMP_W        = 11;
  localparam int FCNT_W        = 2;

  // Register port
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AW-1:0] REG_STATUS   = 8'h04;
  localparam logic [AW-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [AW-1:0] REG_RAMP     = 8'h10;

  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_ST_LSB   = 0;
  localparam int STAT_FCNT_LSB = 3;
  localparam int STAT_PG_BIT   = 5;
  localparam int STAT_FLT_BIT  = 6;
  localparam int IRQ_OV        = 0;
  localparam int IRQ_UV        = 1;
  localparam int IRQ_OC        = 2;
  localparam int IRQ_LATCH     = 3;
  localparam int IRQ_W         = 4;

  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  localparam logic             CTRL_EN_RESET = 1'b0;

  // Comparator results from the analog front end
  typedef struct packed {
    logic ov_trip;
    logic uv_trip;
    logic oc_trip;
    logic in_window;
    logic above_min;
  } cfps_cmp_t;

  localparam int CMP_W = 5;

  // Gate enables: high side and low side of both phases
  typedef struct packed {
    logic hs1;
    logic hs2;
    logic ls1;
    logic ls2;
  } cfps_gate_t;

  localparam cfps_gate_t GATE_OFF     = 4'h0;
  localparam cfps_gate_t GATE_SWITCH  = 4'hf;
  localparam cfps_gate_t GATE_CROWBAR = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SOFT,
    ST_RUN,
    ST_HICCUP,
    ST_OVP,
    ST_LATCH
  } cfps_state_t;

endpackage : cfps_pkg

// ===== cfps_sync.sv
`timescale 1ns/1ps
module cfps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  initial
  begin
    if (W < 1)
      $error("cfps_sync: W must be at least 1");
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Take a bit once the last two stages agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dout <= '0;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
      end
    end
  end

endmodule : cfps_sync

// ===== cfps_ramp.sv
`timescale 1ns/1ps
module cfps_ramp #(
  parameter int STEPS = 2048,
  parameter int W     = 11
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         run,
  input  wire logic         clear,
  output logic      [W-1:0] count,
  output logic              done
);

  localparam logic [W-1:0] LAST = W'(STEPS - 1);

  initial
  begin
    if (STEPS < 2 || STEPS > (1 << W))
      $error("cfps_ramp: STEPS does not fit W");
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (run && count != LAST)
      count <= count + W'(1);
  end

  assign done = (count == LAST);

endmodule : cfps_ramp

// ===== cfps_sequencer.sv
`timescale 1ns/1ps
module cfps_sequencer
  import cfps_pkg::*;
#(
  parameter int RAMP_N   = RAMP_STEPS,
  parameter int HICCUP_N = HICCUP_CYCLES,
  parameter int LIMIT_N  = FAULT_LIMIT
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  cfps_pkg::cfps_cmp_t         cmp_pins,
  input  wire logic [cfps_pkg::AW-1:0] addr,
  input  wire logic [cfps_pkg::DW-1:0] wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [cfps_pkg::DW-1:0] rdata,
  output logic                        irq,
  output logic                        pgood_out,
  output logic                        pgood_oe,
  output logic                        osc_inhibit_fault_pin,
  output cfps_pkg::cfps_gate_t        gate,
  output logic [cfps_pkg::RAMP_W-1:0] ss_ref
);
  import cfps_pkg::*;

  initial
  begin
    if (RAMP_N > (1 << RAMP_W) || HICCUP_N < 2 || HICCUP_N > 65536)
      $error("cfps_sequencer: ramp or hiccup length out of range");
    if (LIMIT_N < 1 || LIMIT_N > (1 << FCNT_W) - 1)
      $error("cfps_sequencer: fault limit does not fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Inputs and ramp

  cfps_cmp_t         cmp_s;
  cfps_state_t       state_r;
  cfps_state_t       state_nxt;
  logic              uv_prev_r;
  logic              uv_evt;
  logic              oc_evt;
  logic              ov_evt;
  logic              fault_evt;
  logic [FCNT_W-1:0] fcnt_r;
  logic [15:0]       hic_cnt_r;
  logic              hic_done;
  logic [RAMP_W-1:0] ramp_cnt;
  logic              ramp_done;
  logic              ctrl_en_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_set;

  localparam logic [FCNT_W-1:0] FCNT_LAST = FCNT_W'(LIMIT_N - 1);
  localparam logic [15:0]       HIC_LAST  = 16'(HICCUP_N - 1);

  cfps_sync #(
    .W (CMP_W)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (cmp_pins),
    .dout    (cmp_s)
  );

  cfps_ramp #(
    .STEPS (RAMP_N),
    .W     (RAMP_W)
  ) u_ramp (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (state_r == ST_SOFT),
    .clear   (state_r != ST_SOFT && state_r != ST_RUN),
    .count   (ramp_cnt),
    .done    (ramp_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Fault detection

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      uv_prev_r <= 1'b0;
    else
      uv_prev_r <= cmp_s.uv_trip;
  end

  always_comb
  begin
    // Over-voltage watched in every live state
    ov_evt = cmp_s.ov_trip && state_r != ST_OVP;
    uv_evt = cmp_s.uv_trip && uv_prev_r && !ov_evt &&
             (state_r == ST_RUN || (state_r == ST_SOFT && cmp_s.above_min));
    oc_evt = cmp_s.oc_trip && !ov_evt && (state_r == ST_RUN || state_r == ST_SOFT);
    fault_evt = uv_evt || oc_evt;
  end

  // Shared count of under-voltage and over-current
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fcnt_r <= '0;
    else if (fault_evt && fcnt_r != FCNT_LAST)
      fcnt_r <= fcnt_r + FCNT_W'(1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hic_cnt_r <= '0;
    else if (state_r == ST_HICCUP)
      hic_cnt_r <= hic_cnt_r + 16'h0001;
    else
      hic_cnt_r <= '0;
  end

  assign hic_done = (hic_cnt_r == HIC_LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (ov_evt)
          state_nxt = ST_OVP;
        else if (ctrl_en_r)
          state_nxt = ST_SOFT;
      ST_SOFT, ST_RUN:
        if (ov_evt)
          state_nxt = ST_OVP;
        else if (fault_evt)
          state_nxt = (fcnt_r == FCNT_LAST) ? ST_LATCH : ST_HICCUP;
        else if (state_r == ST_SOFT && ramp_done)
          state_nxt = ST_RUN;
      ST_HICCUP:
        if (ov_evt)
          state_nxt = ST_OVP;
        else if (hic_done)
          state_nxt = ST_SOFT;
      ST_LATCH:
        if (ov_evt)
          state_nxt = ST_OVP;
      ST_OVP:
        state_nxt = ST_OVP;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Crowbar or all off outside switching
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      gate <= GATE_OFF;
    else if (state_nxt == ST_OVP)
      gate <= GATE_CROWBAR;
    else if (state_nxt == ST_SOFT || state_nxt == ST_RUN)
      gate <= GATE_SWITCH;
    else
      gate <= GATE_OFF;
  end

  // Fault pin sticky to power cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      osc_inhibit_fault_pin <= 1'b0;
    else if (state_nxt == ST_OVP || state_nxt == ST_LATCH)
      osc_inhibit_fault_pin <= 1'b1;
  end

  // Open drain pulled low out of window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pgood_out <= 1'b0;
      pgood_oe  <= 1'b1;
    end
    else
    begin
      pgood_out <= 1'b0;
      pgood_oe  <= !(state_r == ST_RUN && cmp_s.in_window);
    end
  end

  // Ramp code is the comparator reference
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ss_ref <= '0;
    else
      ss_ref <= ramp_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_en_r <= CTRL_EN_RESET;
    else if (wr_en && addr == REG_CTRL)
      ctrl_en_r <= wdata[CTRL_EN_BIT];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_mask_r <= IRQ_RESET;
    else if (wr_en && addr == REG_IRQ_MASK)
      irq_mask_r <= wdata[IRQ_W-1:0];
  end

  always_comb
  begin
    irq_set            = '0;
    irq_set[IRQ_OV]    = ov_evt;
    irq_set[IRQ_UV]    = uv_evt;
    irq_set[IRQ_OC]    = oc_evt;
    irq_set[IRQ_LATCH] = (state_nxt == ST_LATCH && state_r != ST_LATCH);
  end

  // Set wins over a write-one clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat_r <= IRQ_RESET;
    else if (wr_en && addr == REG_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~wdata[IRQ_W-1:0]) | irq_set;
    else
      irq_stat_r <= irq_stat_r | irq_set;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_r & irq_mask_r);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= '0;
    else if (rd_en)
    begin
      rdata <= '0;
      case (addr)
        REG_CTRL:     rdata[CTRL_EN_BIT] <= ctrl_en_r;
        REG_STATUS:
        begin
          rdata[STAT_ST_LSB +: 3]        <= state_r;
          rdata[STAT_FCNT_LSB +: FCNT_W] <= fcnt_r;
          rdata[STAT_PG_BIT]             <= !pgood_oe;
          rdata[STAT_FLT_BIT]            <= osc_inhibit_fault_pin;
        end
        REG_IRQ_STAT: rdata[IRQ_W-1:0] <= irq_stat_r;
        REG_IRQ_MASK: rdata[IRQ_W-1:0] <= irq_mask_r;
        REG_RAMP:     rdata[RAMP_W-1:0] <= ramp_cnt;
        default:      rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] chk_hic_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      chk_hic_r <= '0;
    else if (state_r == ST_HICCUP)
      chk_hic_r <= chk_hic_r + 16'h0001;
    else
      chk_hic_r <= '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_pg_window;
    (state_r == ST_RUN && !cmp_s.in_window) |=> pgood_oe && !pgood_out;
  endproperty
  a_pg_window: assert property (p_pg_window) else $error("pgood not low off window");

  property p_pg_ramp;
    (state_r != ST_RUN) |=> pgood_oe;
  endproperty
  a_pg_ramp: assert property (p_pg_ramp) else $error("pgood released before ramp");

  property p_ov_crowbar;
    ov_evt |=> (gate == GATE_CROWBAR && state_r == ST_OVP) [*4];
  endproperty
  a_ov_crowbar: assert property (p_ov_crowbar) else $error("crowbar not held");

  property p_ov_fault;
    ov_evt |=> osc_inhibit_fault_pin ##1 osc_inhibit_fault_pin;
  endproperty
  a_ov_fault: assert property (p_ov_fault) else $error("fault pin not set on OV");

  property p_uv_off;
    uv_evt |-> $past(cmp_s.uv_trip) ##1 (gate == GATE_OFF);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("UV shutdown wrong");

  property p_hiccup_len;
    (state_r == ST_HICCUP && state_nxt == ST_SOFT) |-> chk_hic_r == HIC_LAST;
  endproperty
  a_hiccup_len: assert property (p_hiccup_len) else $error("hiccup wait length wrong");

  property p_third_latch;
    (fault_evt && fcnt_r == FCNT_LAST) |=> state_r == ST_LATCH && osc_inhibit_fault_pin;
  endproperty
  a_third_latch: assert property (p_third_latch) else $error("no latch on limit");

  property p_uv_gate_ss;
    (state_r == ST_SOFT && !cmp_s.above_min && !cmp_s.oc_trip && !cmp_s.ov_trip)
      |=> (state_r == ST_SOFT || state_r == ST_RUN);
  endproperty
  a_uv_gate_ss: assert property (p_uv_gate_ss) else $error("UV checked below 0.8V");

  property p_ref_ramp;
    (state_r == ST_SOFT) |=> ss_ref == $past(ramp_cnt);
  endproperty
  a_ref_ramp: assert property (p_ref_ramp) else $error("reference not following ramp");

  property p_oc_hiccup;
    (oc_evt && fcnt_r != FCNT_LAST) |=> state_r == ST_HICCUP && gate == GATE_OFF;
  endproperty
  a_oc_hiccup: assert property (p_oc_hiccup) else $error("OC not to hiccup");

  property p_latch_hold;
    (state_r == ST_LATCH && !ov_evt) |=> state_r == ST_LATCH;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released");

  property p_ramp_step;
    (state_r == ST_SOFT && $past(state_r) == ST_SOFT && !ramp_done)
      |=> ramp_cnt == $past(ramp_cnt) + RAMP_W'(1);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

  c_run:    cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
  c_hiccup: cover property (state_r == ST_HICCUP ##1 state_r == ST_SOFT);
  c_latch:  cover property (state_r != ST_LATCH ##1 state_r == ST_LATCH);
  c_ovp:    cover property (state_r == ST_RUN ##1 state_r == ST_OVP);

endmodule : cfps_sequencer

// ===== cfps_front_model.sv
`timescale 1ns/1ps
module cfps_front_model
#(
  parameter int MIN_CODE = 4
) (
  input  wire logic                        ov_req,
  input  wire logic                        uv_req,
  input  wire logic                        oc_req,
  input  wire logic                        win_bad,
  input  cfps_pkg::cfps_gate_t             gate,
  input  wire logic [cfps_pkg::RAMP_W-1:0] ss_ref,
  output cfps_pkg::cfps_cmp_t              cmp_pins
);
  import cfps_pkg::*;
  logic sw;
  assign sw = (gate == GATE_SWITCH);
  assign cmp_pins.ov_trip = ov_req;
  // Output collapses while switches are off
  assign cmp_pins.uv_trip   = uv_req | !sw;
  assign cmp_pins.oc_trip   = oc_req;
  assign cmp_pins.in_window = sw & !win_bad & !uv_req & !ov_req;
  assign cmp_pins.above_min = sw & (ss_ref >= MIN_CODE) & !uv_req;
endmodule : cfps_front_model

// ===== cfps_sequencer_tb.sv
`timescale 1ns/1ps
module cfps_sequencer_tb;
  import cfps_pkg::*;
  localparam int RN = 16;
  localparam int HN = 16;
  logic              clk, reset_n, wr_en, rd_en, irq, pgood_out, pgood_oe;
  logic              osc_inhibit_fault_pin, ov_req, uv_req, oc_req, win_bad;
  logic [AW-1:0]     addr;
  logic [DW-1:0]     wdata, rdata, d;
  logic [RAMP_W-1:0] ss_ref, a;
  cfps_cmp_t         cmp_pins;
  cfps_gate_t        gate;
  int                n_mismatch, comparisons, n;

  cfps_sequencer #(.RAMP_N(RN), .HICCUP_N(HN), .LIMIT_N(3)) dut_u (
    .clk(clk), .reset_n(reset_n), .cmp_pins(cmp_pins), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .pgood_out(pgood_out),
    .pgood_oe(pgood_oe), .osc_inhibit_fault_pin(osc_inhibit_fault_pin), .gate(gate),
    .ss_ref(ss_ref));
  cfps_front_model front_u (
    .ov_req(ov_req), .uv_req(uv_req), .oc_req(oc_req), .win_bad(win_bad),
    .gate(gate), .ss_ref(ss_ref), .cmp_pins(cmp_pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] ad, input logic [DW-1:0] dt);
    @(posedge clk);
    addr  <= ad;
    wdata <= dt;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] ad);
    @(posedge clk);
    addr  <= ad;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic rdm(input logic [AW-1:0] ad, input logic [DW-1:0] m,
                     input logic [DW-1:0] exp);
    rd(ad);
    chk(d & m, exp);
  endtask : rdm

  task automatic wait_st(input logic [2:0] s, input int lim);
    n = 0;
    do
    begin
      rd(REG_STATUS);
      n++;
    end
    while (d[2:0] !== s && n < lim);
    chk(d[2:0], s);
  endtask : wait_st

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : settle

  // Off time measured from switch-off to restart
  task automatic hic();
    n = 0;
    while (gate !== GATE_OFF && n < 50)
    begin
      settle(1);
      n++;
    end
    ov_req <= 1'b0;
    uv_req <= 1'b0;
    oc_req <= 1'b0;
    n = 0;
    while (gate === GATE_OFF && n < 10 * HN)
    begin
      settle(1);
      n++;
    end
    chk(n, HN);
    chk(gate, GATE_SWITCH);
  endtask : hic

  task automatic wrap_up();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #100us;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {reset_n, wr_en, rd_en, ov_req, uv_req, oc_req, win_bad} = '0;
    addr  = '0;
    wdata = '0;
    n_mismatch  = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    chk(pgood_oe, 1'b1);
    chk(pgood_out, 1'b0);
    chk(gate, GATE_OFF);
    chk(osc_inhibit_fault_pin, 1'b0);
    chk(irq, 1'b0);
    rdm(REG_CTRL, '1, '0);
    rdm(REG_STATUS, '1, '0);
    rdm(REG_IRQ_MASK, '1, '0);
    rdm(8'h20, '1, '0);
    wr(REG_STATUS, '1);
    rdm(REG_STATUS, '1, '0);
    wr(REG_IRQ_MASK, 32'h0000000f);
    wr(REG_CTRL, 32'h00000001);
    wait_st(3'd1, 5);
    chk(pgood_oe, 1'b1);
    a = ss_ref;
    settle(1);
    if (a < RN - 2)
      chk(ss_ref, a + 1'b1);
    wait_st(3'd2, RN + 10);
    chk(gate, GATE_SWITCH);
    rdm(REG_RAMP, '1, RN - 1);
    settle(8);
    chk(pgood_oe, 1'b0);
    chk(pgood_out, 1'b0);
    win_bad <= 1'b1;
    settle(8);
    chk(pgood_oe, 1'b1);
    win_bad <= 1'b0;
    settle(8);
    chk(pgood_oe, 1'b0);
    @(posedge clk);
    uv_req <= 1'b1;
    @(posedge clk);
    uv_req <= 1'b0;
    settle(8);
    rdm(REG_STATUS, 32'h7, 32'h2);
    oc_req <= 1'b1;
    hic();
    rdm(REG_STATUS, 32'h1f, 32'h09);
    chk(irq, 1'b1);
    rdm(REG_IRQ_STAT, 32'hf, 32'h4);
    wr(REG_IRQ_STAT, 32'h4);
    settle(2);
    chk(irq, 1'b0);
    wait_st(3'd2, RN + 10);
    uv_req <= 1'b1;
    hic();
    rdm(REG_STATUS, 32'h18, 32'h10);
    rdm(REG_IRQ_STAT, 32'hf, 32'h2);
    wr(REG_IRQ_MASK, '0);
    wr(REG_IRQ_STAT, 32'hf);
    wait_st(3'd2, RN + 10);
    oc_req <= 1'b1;
    wait_st(3'd5, 20);
    oc_req <= 1'b0;
    chk(osc_inhibit_fault_pin, 1'b1);
    chk(gate, GATE_OFF);
    rdm(REG_IRQ_STAT, 32'h8, 32'h8);
    chk(irq, 1'b0);
    wr(REG_IRQ_MASK, 32'h8);
    settle(2);
    chk(irq, 1'b1);
    settle(3 * HN);
    wr(REG_CTRL, '0);
    wr(REG_CTRL, 32'h1);
    rdm(REG_STATUS, 32'h47, 32'h45);
    @(posedge clk);
    reset_n <= 1'b0;
    settle(2);
    @(posedge clk);
    reset_n <= 1'b1;
    chk(osc_inhibit_fault_pin, 1'b0);
    wr(REG_CTRL, 32'h1);
    wait_st(3'd1, 5);
    ov_req <= 1'b1;
    wait_st(3'd4, 20);
    ov_req <= 1'b0;
    settle(3 * HN);
    chk(gate, GATE_CROWBAR);
    chk(osc_inhibit_fault_pin, 1'b1);
    rdm(REG_STATUS, 32'h7, 32'h4);
    wrap_up();
  end
endmodule : cfps_sequencer_tb
